/* File: verilog/cpu_ctrl_cfg.svh */
/*
 * constants of the mode and exception control block: status word fields,
 * mode codes, system register addresses, reset values, stack frame layout.
 * assumes inclusion by bare name from the design files.
 */
`ifndef CPU_CTRL_CFG_SVH
`define CPU_CTRL_CFG_SVH

// status word, lower halfword
`define PSW_C 0
`define PSW_Z 1
`define PSW_N 2
`define PSW_V 3
`define PSW_Q 4
`define PSW_L 5
`define PSW_T 14
`define PSW_R 15
// status word, upper halfword
`define PSW_GM 16
`define PSW_I0M 17
`define PSW_I3M 20
`define PSW_M_LSB 22
`define PSW_M_MSB 24
`define PSW_D 26
`define PSW_LO_WMASK 16'hc03f
`define PSW_WMASK 32'h05ff_c03f
`define PSW_RESET 32'h0040_0000

// mode codes held in the mode field
`define MODE_APP 3'h0
`define MODE_SUP 3'h1
`define MODE_INTERRUPT_LEVEL_ZERO 3'h2
`define MODE_INTERRUPT_LEVEL_THREE 3'h5
`define MODE_EXC 3'h6
`define MODE_NMI 3'h7
`define RANK_NONE 3'h7

// system register byte addresses
`define SYSREG_SR 10'h000
`define SYSREG_CONFIGURATION_WORD_ZERO 10'h100
`define CFG0_AR_LSB 13

// stack frame: word index 0..4 scratch group, 5 return address, 6 status
`define CTX_FULL_BASE 3'h0
`define CTX_SHORT_BASE 3'h5
`define CTX_IDX_RA 3'h5
`define CTX_IDX_PSW 3'h6
`define WORD_BYTES 32'h0000_0004
`define SP_RESET 32'h0000_1000

`endif

/* File: verilog/cpu_ctrl_pkg.sv */
/*
 * types shared by the mode and exception control block and its helpers.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package cpu_ctrl_pkg;

    typedef enum logic [1:0] {SZ_BYTE, SZ_HALF, SZ_WORD, SZ_DWORD} access_size_type;

    typedef struct packed {
        logic valid;
        logic write;
        access_size_type size;
        logic [31:0] addr;
    } mem_access_type;

    typedef struct packed {
        logic valid;
        logic simd;
        logic cop;
        logic java;
        logic tlb;
        logic cache;
        logic privileged;
        logic scall;
        logic rete;
        logic rets;
        logic retd;
        logic mfsr;
        logic mtsr;
        logic [9:0] sysreg_addr;
        logic [31:0] sysreg_wdata;
    } instr_class_type;

    typedef enum logic [2:0] {
        CAUSE_NONE, CAUSE_UNIMPL, CAUSE_PRIV, CAUSE_ALIGN, CAUSE_PROT
    } exc_cause_type;

    typedef enum {ST_IDLE, ST_PUSH, ST_POP} seq_state_type;

endpackage

/* File: verilog/mode_arbiter.sv */
/*
 * picks the highest ranked pending request and says whether it may
 * preempt the running mode.  purely combinational.
 * assumes request inputs are held until serviced.
 */
`include "cpu_ctrl_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module mode_arbiter (
    // requests
    input wire logic nmi_req,
    input wire logic exc_req,
    input wire logic [3:0] irq_req,
    // masks and running mode
    input wire logic [3:0] irq_mask,
    input wire logic gm,
    input wire logic [2:0] cur_mode,
    // decision
    output logic take,
    output logic [2:0] sel_mode
);
    logic [3:0] eligible;
    logic [2:0] sel_rank;
    logic [2:0] cur_rank;

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_lvl
            assign eligible[g] = irq_req[g] & ~irq_mask[g] & ~gm;
        end
    endgenerate

    // modes 2..7 rank as 8-mode, so nmi=1 .. level zero=6
    assign cur_rank = (cur_mode >= `MODE_INTERRUPT_LEVEL_ZERO) ? 3'(4'h8 - {1'b0, cur_mode})
                                               : `RANK_NONE;

    always_comb begin
        sel_mode = `MODE_SUP;
        sel_rank = `RANK_NONE;
        for (int i = 0; i < 4; i++) begin
            if (eligible[i]) begin
                sel_mode = 3'(`MODE_INTERRUPT_LEVEL_ZERO + 3'(i));
                sel_rank = 3'(3'h6 - 3'(i));
            end
        end
        if (exc_req) begin
            sel_mode = `MODE_EXC;
            sel_rank = 3'h2;
        end
        if (nmi_req) begin
            sel_mode = `MODE_NMI;
            sel_rank = 3'h1;
        end
        take = sel_rank < cur_rank;
    end
endmodule // mode_arbiter

`default_nettype wire

/* File: verilog/access_checker.sv */
/*
 * data access checker: alignment, protection abort and doubleword split.
 * assumes the requester holds off while ls_busy_r is high.
 */
`include "cpu_ctrl_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module access_checker (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    // request
    input wire cpu_ctrl_pkg::mem_access_type acc,
    input wire logic privileged,
    input wire logic prot_hit,
    // issued access
    output logic dmem_valid_r,
    output logic dmem_write_r,
    output cpu_ctrl_pkg::access_size_type dmem_size_r,
    output logic [31:0] dmem_addr_r,
    output logic ls_busy_r,
    // faults
    output logic align_fault_r,
    output logic prot_fault_r
);
    import cpu_ctrl_pkg::*;

    logic misalign;

    always_comb begin
        case (acc.size)
            SZ_HALF: misalign = acc.addr[0];
            SZ_WORD: misalign = |acc.addr[1:0];
            SZ_DWORD: misalign = |acc.addr[1:0];
            default: misalign = 1'b0;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dmem_valid_r <= 1'b0;
            dmem_write_r <= 1'b0;
            dmem_size_r <= SZ_BYTE;
            dmem_addr_r <= 32'h0000_0000;
            ls_busy_r <= 1'b0;
            align_fault_r <= 1'b0;
            prot_fault_r <= 1'b0;
        end else if (ce) begin
            align_fault_r <= 1'b0;
            prot_fault_r <= 1'b0;
            if (ls_busy_r) begin
                dmem_valid_r <= 1'b1;
                dmem_addr_r <= dmem_addr_r + `WORD_BYTES;
                ls_busy_r <= 1'b0;
            end else if (acc.valid && misalign) begin
                dmem_valid_r <= 1'b0;
                align_fault_r <= 1'b1;
            end else if (acc.valid && prot_hit && !privileged) begin
                dmem_valid_r <= 1'b0;
                prot_fault_r <= 1'b1;
            end else if (acc.valid) begin
                dmem_valid_r <= 1'b1;
                dmem_write_r <= acc.write;
                dmem_addr_r <= acc.addr;
                // a doubleword goes out as two word beats
                dmem_size_r <= (acc.size == SZ_DWORD) ? SZ_WORD : acc.size;
                ls_busy_r <= acc.size == SZ_DWORD;
            end else begin
                dmem_valid_r <= 1'b0;
            end
        end
    end
endmodule // access_checker

`default_nettype wire

/* File: verilog/cpu_mode_exception_control.sv */
/*
 * execution mode, exception and stacked context control of the core.
 * assumes a stack memory that answers with stk_ready (read data valid in the
 * same cycle) and a pipeline that stalls while busy_r is high.
 */
// Behaviour
// - interrupt entry pushes scratch group, any level
// - interrupt entry also pushes return address, status
// - interrupt return restores scratch, status, then resumes
// - no shadow banks, context lives on stack
// - exception or supervisor call saves status, return
// - exception and supervisor return instructions pop status and resume address
// - protected access aborted, exception taken
// - misaligned access faults; doubleword needs word
// - doubleword access split into two words
// - unimplemented instruction classes raise exception
// - read-only architecture revision in configuration word
// - status word lower flags, upper mode
// - status lower halfword resets to zero
// - mode priorities one to six
// - only higher priority preempts running mode
// - application mode restricted instructions, registers, memory
// - all other modes are privileged
// - supervisor mode after reset
// - debug state grants full privileged access
// - debug entry masks all interrupt levels
// - debug left by debug return, privileged status word move or stack return
// - system registers only via move instructions
`include "cpu_ctrl_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module cpu_mode_exception_control #(
    parameter logic [2:0] ARCH_REV = 3'h3,
    parameter logic COP_PRESENT = 1'b0,
    parameter logic [31:0] SP_INIT = `SP_RESET
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    // event sources
    input wire logic nmi_req,
    input wire logic [3:0] irq_req,
    input wire logic debug_req,
    // retiring instruction and its context
    input wire cpu_ctrl_pkg::instr_class_type instr,
    input wire logic [31:0] return_pc,
    input wire logic [4:0][31:0] scratch_gpr_group,
    input wire logic flags_wr,
    input wire logic [15:0] flags_wdata,
    input wire logic sp_wr,
    input wire logic [31:0] sp_wdata,
    // data access
    input wire cpu_ctrl_pkg::mem_access_type dacc,
    input wire logic prot_hit,
    output logic dmem_valid_r,
    output logic dmem_write_r,
    output cpu_ctrl_pkg::access_size_type dmem_size_r,
    output logic [31:0] dmem_addr_r,
    output logic ls_busy_r,
    // system stack memory
    output logic stk_valid_r,
    output logic stk_write_r,
    output logic [31:0] stk_addr_r,
    output logic [31:0] stk_wdata_r,
    input wire logic stk_ready,
    input wire logic [31:0] stk_rdata,
    // state and results
    output logic [31:0] processor_status_word_r,
    output logic [31:0] system_stack_pointer_r,
    output logic [31:0] sysreg_rdata_r,
    output logic busy_r,
    output logic ctx_enter_r,
    output logic [2:0] entry_mode_r,
    output cpu_ctrl_pkg::exc_cause_type exc_cause_r,
    output logic resume_r,
    output logic [31:0] resume_pc_r,
    output logic restore_valid_r,
    output logic [6:0][31:0] frame_r
);
    import cpu_ctrl_pkg::*;

    seq_state_type state_r;
    logic [2:0] idx_r;
    logic [2:0] base_r;
    logic exc_pend_r;
    logic [31:0] dbg_psw_r;
    logic [31:0] dbg_ra_r;

    logic [2:0] mode;
    logic dbg;
    logic priv;
    logic irq_mode;
    logic idle;
    logic sr_sel;
    logic unimpl;
    logic priv_viol;
    logic align_fault;
    logic prot_fault;
    logic take;
    logic [2:0] sel_mode;
    logic go_take;
    logic go_dbg;
    logic ins_ok;
    logic go_scall;
    logic go_ret;
    logic go_retd;
    logic go_push;
    logic push_full;
    logic seq_last;
    logic fin_push;
    logic fin_pop;

    assign mode = processor_status_word_r[`PSW_M_MSB:`PSW_M_LSB];
    assign dbg = processor_status_word_r[`PSW_D];
    assign priv = (mode != `MODE_APP) | dbg;
    assign irq_mode = (mode >= `MODE_INTERRUPT_LEVEL_ZERO) && (mode <= `MODE_INTERRUPT_LEVEL_THREE);
    assign idle = state_r == ST_IDLE;
    assign sr_sel = instr.sysreg_addr == `SYSREG_SR;

    assign unimpl = idle & instr.valid & (instr.simd | (instr.cop & ~COP_PRESENT)
                    | instr.java | instr.tlb | instr.cache);
    // the status word is the only system register open to application code
    assign priv_viol = idle & instr.valid & ~priv & (instr.privileged | instr.rete
                       | instr.rets | instr.retd
                       | ((instr.mfsr | instr.mtsr) & ~sr_sel));

    mode_arbiter u_arb (
        .nmi_req(nmi_req),
        .exc_req(exc_pend_r),
        .irq_req(irq_req),
        .irq_mask(processor_status_word_r[`PSW_I3M:`PSW_I0M]),
        .gm(processor_status_word_r[`PSW_GM]),
        .cur_mode(mode),
        .take(take),
        .sel_mode(sel_mode)
    );

    access_checker u_chk (
        .clk(clk),
        .arst_n(arst_n),
        .ce(ce),
        .acc(dacc),
        .privileged(priv),
        .prot_hit(prot_hit),
        .dmem_valid_r(dmem_valid_r),
        .dmem_write_r(dmem_write_r),
        .dmem_size_r(dmem_size_r),
        .dmem_addr_r(dmem_addr_r),
        .ls_busy_r(ls_busy_r),
        .align_fault_r(align_fault),
        .prot_fault_r(prot_fault)
    );

    // a preempting request beats debug entry, which beats the instruction
    assign go_take = ce & idle & take;
    assign go_dbg = ce & idle & ~take & debug_req & ~dbg;
    assign ins_ok = ce & idle & ~take & ~(debug_req & ~dbg) & instr.valid
                    & ~unimpl & ~priv_viol;
    assign go_scall = ins_ok & instr.scall;
    assign go_ret = ins_ok & (instr.rete | instr.rets);
    assign go_retd = ins_ok & instr.retd & dbg;
    assign go_push = go_take | go_scall;
    assign push_full = go_take && (sel_mode >= `MODE_INTERRUPT_LEVEL_ZERO) && (sel_mode <= `MODE_INTERRUPT_LEVEL_THREE);
    assign seq_last = stk_ready & (state_r == ST_PUSH ? idx_r == `CTX_IDX_PSW
                                                      : idx_r == base_r);
    assign fin_push = ce & (state_r == ST_PUSH) & seq_last;
    assign fin_pop = ce & (state_r == ST_POP) & seq_last;

    // stack sequencer; the stack pointer moves at each word issued
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= ST_IDLE;
            idx_r <= 3'h0;
            base_r <= 3'h0;
            busy_r <= 1'b0;
            frame_r <= '0;
            system_stack_pointer_r <= SP_INIT;
            stk_valid_r <= 1'b0;
            stk_write_r <= 1'b0;
            stk_addr_r <= 32'h0000_0000;
            stk_wdata_r <= 32'h0000_0000;
        end else if (ce) begin
            case (state_r)
                ST_IDLE: begin
                    if (go_push) begin
                        // frame has no hardware copy beyond this transfer buffer
                        frame_r <= {processor_status_word_r, return_pc,
                                    scratch_gpr_group};
                        base_r <= push_full ? `CTX_FULL_BASE : `CTX_SHORT_BASE;
                        idx_r <= push_full ? `CTX_FULL_BASE : `CTX_SHORT_BASE;
                        stk_wdata_r <= push_full ? scratch_gpr_group[0] : return_pc;
                        stk_valid_r <= 1'b1;
                        stk_write_r <= 1'b1;
                        stk_addr_r <= system_stack_pointer_r - `WORD_BYTES;
                        system_stack_pointer_r <= system_stack_pointer_r - `WORD_BYTES;
                        busy_r <= 1'b1;
                        state_r <= ST_PUSH;
                    end else if (go_ret) begin
                        // interrupt frames carry the scratch group, others do not
                        base_r <= (instr.rete && irq_mode) ? `CTX_FULL_BASE
                                                           : `CTX_SHORT_BASE;
                        idx_r <= `CTX_IDX_PSW;
                        stk_valid_r <= 1'b1;
                        stk_write_r <= 1'b0;
                        stk_addr_r <= system_stack_pointer_r;
                        system_stack_pointer_r <= system_stack_pointer_r + `WORD_BYTES;
                        busy_r <= 1'b1;
                        state_r <= ST_POP;
                    end else if (sp_wr) begin
                        system_stack_pointer_r <= sp_wdata;
                    end
                end
                ST_PUSH: begin
                    if (seq_last) begin
                        stk_valid_r <= 1'b0;
                        busy_r <= 1'b0;
                        state_r <= ST_IDLE;
                    end else if (stk_ready) begin
                        idx_r <= idx_r + 3'h1;
                        stk_wdata_r <= frame_r[idx_r + 3'h1];
                        stk_addr_r <= system_stack_pointer_r - `WORD_BYTES;
                        system_stack_pointer_r <= system_stack_pointer_r - `WORD_BYTES;
                    end
                end
                ST_POP: begin
                    if (stk_ready) begin
                        frame_r[idx_r] <= stk_rdata;
                    end
                    if (seq_last) begin
                        stk_valid_r <= 1'b0;
                        busy_r <= 1'b0;
                        state_r <= ST_IDLE;
                    end else if (stk_ready) begin
                        idx_r <= idx_r - 3'h1;
                        stk_addr_r <= system_stack_pointer_r;
                        system_stack_pointer_r <= system_stack_pointer_r + `WORD_BYTES;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                    stk_valid_r <= 1'b0;
                    busy_r <= 1'b0;
                end
            endcase
        end
    end

    // exception pending latch; a new fault wins over the clear
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            exc_pend_r <= 1'b0;
            exc_cause_r <= CAUSE_NONE;
        end else if (ce) begin
            if (unimpl | priv_viol | align_fault | prot_fault) begin
                exc_pend_r <= 1'b1;
                if (unimpl) begin
                    exc_cause_r <= CAUSE_UNIMPL;
                end else if (priv_viol) begin
                    exc_cause_r <= CAUSE_PRIV;
                end else if (align_fault) begin
                    exc_cause_r <= CAUSE_ALIGN;
                end else begin
                    exc_cause_r <= CAUSE_PROT;
                end
            end else if (go_take && sel_mode == `MODE_EXC) begin
                exc_pend_r <= 1'b0;
            end
        end
    end

    // status word
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            processor_status_word_r <= `PSW_RESET;
            dbg_psw_r <= 32'h0000_0000;
            dbg_ra_r <= 32'h0000_0000;
        end else if (ce) begin
            if (go_take) begin
                processor_status_word_r[`PSW_M_MSB:`PSW_M_LSB] <= sel_mode;
            end else if (go_scall) begin
                processor_status_word_r[`PSW_M_MSB:`PSW_M_LSB] <= `MODE_SUP;
            end else if (fin_pop) begin
                processor_status_word_r <= frame_r[`CTX_IDX_PSW];
            end else if (go_dbg) begin
                dbg_psw_r <= processor_status_word_r;
                dbg_ra_r <= return_pc;
                processor_status_word_r[`PSW_D] <= 1'b1;
                processor_status_word_r[`PSW_I3M:`PSW_I0M] <= 4'hf;
            end else if (go_retd) begin
                processor_status_word_r <= dbg_psw_r;
            end else if (ins_ok && instr.mtsr && sr_sel) begin
                if (priv) begin
                    processor_status_word_r <= (instr.sysreg_wdata & `PSW_WMASK)
                        | (processor_status_word_r & ~`PSW_WMASK);
                end else begin
                    // application code reaches the flag halfword only
                    processor_status_word_r[15:0] <= instr.sysreg_wdata[15:0]
                        & `PSW_LO_WMASK;
                end
            end else if (flags_wr) begin
                processor_status_word_r[15:0] <= flags_wdata & `PSW_LO_WMASK;
            end
        end
    end

    // system register reads
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sysreg_rdata_r <= 32'h0000_0000;
        end else if (ce && ins_ok && instr.mfsr) begin
            case (instr.sysreg_addr)
                `SYSREG_SR: sysreg_rdata_r <= priv ? processor_status_word_r
                    : {16'h0000, processor_status_word_r[15:0]};
                `SYSREG_CONFIGURATION_WORD_ZERO: sysreg_rdata_r <= 32'(ARCH_REV) << `CFG0_AR_LSB;
                default: sysreg_rdata_r <= 32'h0000_0000;
            endcase
        end
    end

    // context event reporting
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctx_enter_r <= 1'b0;
            entry_mode_r <= `MODE_SUP;
            resume_r <= 1'b0;
            resume_pc_r <= 32'h0000_0000;
            restore_valid_r <= 1'b0;
        end else if (ce) begin
            ctx_enter_r <= fin_push;
            resume_r <= fin_pop | go_retd;
            restore_valid_r <= fin_pop && base_r == `CTX_FULL_BASE;
            if (go_push) begin
                entry_mode_r <= go_take ? sel_mode : `MODE_SUP;
            end
            if (fin_pop) begin
                resume_pc_r <= (base_r == `CTX_SHORT_BASE) ? stk_rdata
                                                          : frame_r[`CTX_IDX_RA];
            end else if (go_retd) begin
                resume_pc_r <= dbg_ra_r;
            end
        end
    end
endmodule // cpu_mode_exception_control

`default_nettype wire

/* File: dv/cpu_mode_exception_control_props.sv */
/* assertions on the ports of the mode and exception control block.
   assumes one clock domain and the bind below. */
`timescale 1ns/1ps
`default_nettype none
module cpu_mode_exception_control_props (
    // clock, reset, requests
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    input wire cpu_ctrl_pkg::mem_access_type dacc,
    input wire logic prot_hit,
    // watched outputs and the stack ready input
    input wire logic dmem_valid_r,
    input wire logic [31:0] dmem_addr_r,
    input wire logic ls_busy_r,
    input wire logic stk_valid_r,
    input wire logic stk_write_r,
    input wire logic [31:0] stk_addr_r,
    input wire logic stk_ready,
    input wire logic busy_r,
    input wire logic ctx_enter_r,
    input wire logic [31:0] processor_status_word_r
);
    import cpu_ctrl_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    sequence s_push_step;
        ce && stk_valid_r && stk_ready && stk_write_r ##1 stk_valid_r && stk_write_r;
    endsequence
    sequence s_dw_beats;
        dmem_valid_r && ls_busy_r && dmem_addr_r == $past(dacc.addr)
        ##1 dmem_valid_r && !ls_busy_r && dmem_addr_r == $past(dmem_addr_r) + 32'h4;
    endsequence
    a_reset_state: assert property ($rose(arst_n)
        |-> processor_status_word_r == 32'h0040_0000) else $error("bad reset state");
    a_stk_hold: assert property (stk_valid_r && !stk_ready
        |=> stk_valid_r && $stable(stk_addr_r)) else $error("stack request dropped");
    a_stack_busy: assert property (stk_valid_r |-> busy_r)
        else $error("stack use while idle");
    a_push_down: assert property (s_push_step |-> stk_addr_r == $past(stk_addr_r) - 32'h4)
        else $error("push not descending");
    a_pop_up: assert property (ce && stk_valid_r && stk_ready && !stk_write_r
        ##1 stk_valid_r |-> stk_addr_r == $past(stk_addr_r) + 32'h4)
        else $error("pop not ascending");
    a_enter_after_push: assert property (ctx_enter_r
        |-> $past(stk_ready) && $past(stk_write_r)) else $error("entry before push");
    a_dword_split: assert property (ce && dacc.valid && dacc.size == SZ_DWORD && !prot_hit
        && dacc.addr[1:0] == 2'h0 && !ls_busy_r |=> s_dw_beats) else $error("bad split");
    a_misalign_block: assert property (ce && dacc.valid && dacc.size == SZ_WORD
        && dacc.addr[1:0] != 2'h0 && !ls_busy_r |=> !dmem_valid_r) else $error("misaligned issued");
endmodule // cpu_mode_exception_control_props
bind cpu_mode_exception_control cpu_mode_exception_control_props P (.*);
`default_nettype wire

/* File: dv/stack_mem_model.sv */
/* behavioural system stack memory for the control block.
   assumes stack words within a 64-word window. */
`timescale 1ns/1ps
`default_nettype none
module stack_mem_model (
    // stack link
    input wire logic clk,
    input wire logic slow,
    input wire logic stk_valid_r,
    input wire logic stk_write_r,
    input wire logic [31:0] stk_addr_r,
    input wire logic [31:0] stk_wdata_r,
    output logic stk_ready,
    output logic [31:0] stk_rdata
);
    logic [31:0] mem [0:63];
    logic tog = 1'b0;
    always @(posedge clk) begin
        tog <= ~tog;
        if (stk_valid_r && stk_ready && stk_write_r) mem[stk_addr_r[7:2]] <= stk_wdata_r;
    end
    // slow stalls every other cycle; an unanswered read shows inverted data
    assign stk_ready = stk_valid_r && (!slow || tog);
    assign stk_rdata = stk_ready ? mem[stk_addr_r[7:2]] : ~mem[stk_addr_r[7:2]];
endmodule // stack_mem_model
`default_nettype wire

/* File: dv/cpu_mode_exception_control_tb.sv */
/* bench of the mode and exception control block with a stack model.
   assumes the block's default parameters. */
`timescale 1ns/1ps
`default_nettype none
module cpu_mode_exception_control_tb;
    import cpu_ctrl_pkg::*;
    logic clk = 1'b0, arst_n = 1'b0, ce = 1'b1, nmi_req = 1'b0, debug_req = 1'b0;
    logic slow = 1'b0, flags_wr = 1'b0, sp_wr = 1'b0, prot_hit = 1'b0, busy_r, ctx_enter_r;
    logic dmem_valid_r, dmem_write_r, ls_busy_r, stk_valid_r, stk_write_r, stk_ready;
    logic resume_r, restore_valid_r;
    logic [2:0] entry_mode_r;
    logic [3:0] irq_req = '0;
    logic [15:0] flags_wdata = '0;
    logic [31:0] sp_wdata = '0, return_pc = 32'h2468, dmem_addr_r, stk_addr_r, stk_wdata_r;
    logic [31:0] stk_rdata, processor_status_word_r, system_stack_pointer_r;
    logic [31:0] sysreg_rdata_r, resume_pc_r;
    logic [4:0][31:0] scratch_gpr_group = {32'h105, 32'h104, 32'h103, 32'h102, 32'h101};
    logic [6:0][31:0] frame_r;
    instr_class_type instr = '0;
    mem_access_type dacc = '0;
    access_size_type dmem_size_r;
    exc_cause_type exc_cause_r;
    int miscompares = 0, total_checks = 0;
    localparam int RD = 44, RS = 45, RE = 46, SC = 47, MF = 43, MT = 42;
    cpu_mode_exception_control DUT (.*);
    stack_mem_model M (.*);
    initial forever #12.5 clk = ~clk;
    task chk(input logic [31:0] s, e);
        total_checks++;
        if (s !== e) begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task summarize;
        if (miscompares == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task go(input int b, input logic [9:0] a = '0);
        @(posedge clk) #2;
        instr[b] = 1'b1;
        instr.valid = 1'b1;
        instr.sysreg_addr = a;
        @(posedge clk) #2;
        instr = '0;
    endtask
    // bounded wait for a completion pulse; running out counts as a miss
    task w(input bit r);
        int n;
        n = 0;
        while ((r ? resume_r : ctx_enter_r) !== 1'b1 && n < 60) begin
            @(posedge clk) #2;
            n++;
        end
        chk(n < 60, 1'b1);
    endtask
    task t_scall;
        slow = 1'b1;
        go(SC);
        w(0);
        chk(M.mem[63], return_pc);
        chk(M.mem[62], 32'h0040_0000);
        go(RS);
        w(1);
        slow = 1'b0;
        chk(resume_pc_r, return_pc);
    endtask
    task t_irq;
        irq_req = 4'h9;
        w(0);
        irq_req = 4'h1;
        chk(entry_mode_r, 3'h5);
        for (int k = 0; k < 5; k++) chk(M.mem[63 - k], scratch_gpr_group[k]);
        chk(M.mem[58], return_pc);
        // the handler rewrites a stacked scratch word, so only a real pop matches
        M.mem[59] = 32'h1a5;
        repeat (6) @(posedge clk) #2;
        chk(processor_status_word_r[24:22], 3'h5);
        irq_req = '0;
        go(RE);
        w(1);
        for (int k = 0; k < 5; k++)
            chk(frame_r[k], k == 4 ? 32'h1a5 : scratch_gpr_group[k]);
        chk(restore_valid_r, 1'b1);
        chk(processor_status_word_r, 32'h0040_0000);
    endtask
    task t_unimpl;
        for (int b = 49; b < 54; b++) begin
            go(b);
            w(0);
            chk(exc_cause_r, 32'h1);
            chk(entry_mode_r, 3'h6);
            go(RE);
            w(1);
        end
    endtask
    task t_debug;
        go(MF, 10'h100);
        chk(sysreg_rdata_r[15:13], 3'h3);
        debug_req = 1'b1;
        @(posedge clk) #2;
        debug_req = 1'b0;
        go(MF);
        chk(sysreg_rdata_r, 32'h045e_0000);
        go(RD);
        chk(processor_status_word_r, 32'h0040_0000);
    endtask
    task t_mem;
        dacc = '{1'b1, 1'b0, SZ_DWORD, 32'h104};
        @(posedge clk) #2;
        dacc = '0;
        chk(dmem_addr_r, 32'h104);
        @(posedge clk) #2;
        dacc = '{1'b1, 1'b0, SZ_WORD, 32'h102};
        chk(dmem_addr_r, 32'h108);
        @(posedge clk) #2;
        dacc = '0;
        chk(dmem_valid_r, 1'b0);
        w(0);
        chk(exc_cause_r, 32'h3);
    endtask
    task t_app;
        go(MT);
        chk(processor_status_word_r, 32'h0);
        dacc = '{1'b1, 1'b0, SZ_WORD, 32'h200};
        prot_hit = 1'b1;
        @(posedge clk) #2;
        dacc = '0;
        prot_hit = 1'b0;
        chk(dmem_valid_r, 1'b0);
        w(0);
        chk(exc_cause_r, 32'h4);
        go(RE);
        w(1);
        go(MF, 10'h100);
        w(0);
        chk(exc_cause_r, 32'h2);
        chk(sysreg_rdata_r, 32'h045e_0000);
    endtask
    initial begin
        #200000;
        miscompares++;
        summarize;
    end
    initial begin
        repeat (2) @(posedge clk);
        #2 arst_n = 1'b1;
        chk(processor_status_word_r, 32'h0040_0000);
        t_scall;
        t_irq;
        t_unimpl;
        t_debug;
        t_mem;
        t_app;
        summarize;
    end
endmodule // cpu_mode_exception_control_tb
`default_nettype wire
